//--- rtl/core_pkg.sv
package core_pkg;
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [15:0] IO_SPACE_TOP = 16'h003F;
	localparam logic [15:0] STACK_STEP   = 16'h0001;
	localparam logic [7:0]  FLAGS_RESET  = 8'h00;
	localparam logic [2:0]  BLOCK_COUNT  = 3'h4;

	localparam logic [5:0] IO_STACK_POINTER_LOW_BYTE  = 6'h3D;
	localparam logic [5:0] IO_STACK_POINTER_HIGH_BYTE = 6'h3E;
	localparam logic [5:0] IO_RESULT_FLAGS            = 6'h3F;

	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_I = 7;

	localparam logic [3:0] OP_NOP                      = 4'h0;
	localparam logic [3:0] OP_ALU_REG                  = 4'h1;
	localparam logic [3:0] OP_ADD_IMM                  = 4'h2;
	localparam logic [3:0] OP_SUB_IMM                  = 4'h3;
	localparam logic [3:0] OP_AND_IMM                  = 4'h4;
	localparam logic [3:0] OP_LOAD_IMM                 = 4'h5;
	localparam logic [3:0] OP_MUL_INT                  = 4'h6;
	localparam logic [3:0] OP_MUL_FRAC                 = 4'h7;
	localparam logic [3:0] OP_STACK_DATA               = 4'h8;
	localparam logic [3:0] OP_CALL_JUMP                = 4'h9;
	localparam logic [3:0] OP_RELATIVE_SUBROUTINE_CALL = 4'hA;
	localparam logic [3:0] OP_RETURN_GROUP             = 4'hB;
	localparam logic [3:0] OP_LOAD_STORE               = 4'hC;
	localparam logic [3:0] OP_IO_IN                    = 4'hD;
	localparam logic [3:0] OP_IO_OUT                   = 4'hE;

	localparam logic [1:0] FN_SUBROUTINE_RETURN        = 2'h0;
	localparam logic [1:0] FN_INTERRUPT_RETURN         = 2'h1;
	localparam logic [1:0] FN_INDIRECT_SUBROUTINE_CALL = 2'h2;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} data_req_type;
endpackage

//--- rtl/cpu_core_stack_alu.sv
// Operation
// - Prefetch next word while current one executes.
// - Register or immediate arithmetic in one cycle.
// - Every ALU operation except load immediate updates result flags.
// - Multiplier gives 16-bit product: unsigned, signed, signed by unsigned.
// - Each multiply takes exactly two cycles.
// - Reset starts execution at address zero.
// - Program counter holds next word to fetch.
// - Fetch handles one-word and two-word instructions.
// - Return address is saved as word address.
// - Reset puts stack pointer at SRAM top.
// - Stack pointer is two I/O byte registers.
// - Push decrements, pop increments by one.
// - Calls subtract two, returns add two.
// - Return low byte goes to higher address.
// - Low pointer write holds off interrupts briefly.
// - Flags are never saved or restored automatically.
// - Core runs on undivided core clock.
// - Direct data addressing spans 64 KB.
// - ALU reaches thirty-two 8-bit working registers.
module cpu_core_stack_alu #(
	parameter logic [15:0] SRAM_TOP = 16'h0FFF
) (
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	output logic [15:0]               prog_addr,
	input  wire logic [15:0]          prog_data,
	output core_pkg::data_req_type    data_req,
	input  wire logic [7:0]           data_rdata,
	input  wire logic                 irq_req,
	input  wire logic [15:0]          irq_vector,
	output logic                      irq_ack,
	output logic [15:0]               stack_top_pointer
);
	// The stack must sit above the I/O space or pushes would hit registers.
	if (SRAM_TOP <= core_pkg::IO_SPACE_TOP) begin : g_bad_top
		$error("SRAM_TOP must lie above the I/O space.");
	end

	typedef enum logic [2:0] {
		st_exec, st_second, st_mul, st_push_high, st_pop_high, st_pop_low, st_read_wait
	} state_type;

	state_type               state_reg;
	logic [7:0]              gpr [32];
	logic [15:0]             program_counter_reg;
	logic [15:0]             stack_top_pointer_reg;
	logic [15:0]             return_addr_reg;
	logic [15:0]             target_reg;
	logic [15:0]             ir_reg;
	logic [7:0]              result_flags_register_reg;
	logic [7:0]              temp_byte_reg;
	logic [2:0]              irq_block_reg;
	logic [4:0]              dest_reg;
	logic                    fetch_valid_reg;
	logic                    irq_ack_reg;
	logic                    interrupt_return_reg;
	core_pkg::data_req_type  data_req_reg;
	core_pkg::data_req_type  req_next;

	logic [3:0]  op;
	logic [1:0]  func;
	logic [4:0]  rd;
	logic [4:0]  rr;
	logic [4:0]  rdi;
	logic [5:0]  io;
	logic [3:0]  ir_op;
	logic [4:0]  ir_rd;
	logic        take_irq;
	logic        run;
	logic        push_start;
	logic        stack_down;
	logic        stack_up;
	logic [15:0] push_return;
	logic [15:0] push_target;
	logic [1:0]  alu_kind;
	logic [4:0]  alu_dest;
	logic [12:0] alu_out;
	logic        alu_write;
	logic [7:0]  mul_a;
	logic [7:0]  mul_b;
	logic [15:0] mul_out;
	logic [7:0]  io_read;

	function automatic logic io_internal(input logic [5:0] a);
		return a == core_pkg::IO_STACK_POINTER_LOW_BYTE ||
			a == core_pkg::IO_STACK_POINTER_HIGH_BYTE || a == core_pkg::IO_RESULT_FLAGS;
	endfunction

	// Result packs {S, V, N, Z, C, value}.
	function automatic logic [12:0] alu_op(input logic [7:0] a, input logic [7:0] b,
		input logic [1:0] kind);
		logic [8:0] sum;
		logic       v;
		sum = 9'h000;
		v = 1'b0;
		case (kind)
			2'h0: begin
				sum = {1'b0, a} + {1'b0, b};
				v = (a[7] == b[7]) && (sum[7] != a[7]);
			end
			2'h1: begin
				sum = {1'b0, a} - {1'b0, b};
				v = (a[7] != b[7]) && (sum[7] != a[7]);
			end
			2'h2: sum = {1'b0, a & b};
			default: sum = {1'b0, a ^ b};
		endcase
		return {sum[7] ^ v, v, sum[7], sum[7:0] == 8'h00, sum[8], sum[7:0]};
	endfunction

	// Signedness: 0 both unsigned, 1 both signed, 2 signed by unsigned.
	function automatic logic [15:0] product(input logic [7:0] a, input logic [7:0] b,
		input logic [1:0] sgn, input logic frac);
		logic signed [8:0]  sa;
		logic signed [8:0]  sb;
		logic signed [17:0] p;
		sa = $signed({(sgn != 2'h0) & a[7], a});
		sb = $signed({(sgn == 2'h1) & b[7], b});
		p = sa * sb;
		return frac ? {p[14:0], 1'b0} : p[15:0];
	endfunction

	assign op = prog_data[15:12];
	assign rd = prog_data[11:7];
	assign rr = prog_data[6:2];
	assign func = prog_data[1:0];
	assign rdi = {1'b1, prog_data[11:8]};
	assign io = prog_data[5:0];
	assign ir_op = ir_reg[15:12];
	assign ir_rd = ir_reg[11:7];

	assign take_irq = state_reg == st_exec && fetch_valid_reg && irq_req &&
		result_flags_register_reg[core_pkg::FLAG_I] && irq_block_reg == 3'h0;
	assign run = state_reg == st_exec && fetch_valid_reg && !take_irq;

	assign alu_kind = op == core_pkg::OP_ALU_REG ? func : 2'(op - core_pkg::OP_ADD_IMM);
	assign alu_dest = op == core_pkg::OP_ALU_REG ? rd : rdi;
	assign alu_write = run && op >= core_pkg::OP_ALU_REG && op <= core_pkg::OP_LOAD_IMM;
	assign alu_out = alu_op(gpr[alu_dest], op == core_pkg::OP_ALU_REG ? gpr[rr] : prog_data[7:0],
		alu_kind);
	assign mul_a = gpr[ir_rd];
	assign mul_b = gpr[ir_reg[6:2]];
	assign mul_out = product(mul_a, mul_b, ir_reg[1:0], ir_op == core_pkg::OP_MUL_FRAC);

	always_comb begin
		case (io)
			core_pkg::IO_STACK_POINTER_LOW_BYTE: io_read = stack_top_pointer_reg[7:0];
			core_pkg::IO_STACK_POINTER_HIGH_BYTE: io_read = temp_byte_reg;
			default: io_read = result_flags_register_reg;
		endcase
	end

	// Program counter counts 16-bit words, so it already is the word address.
	always_comb begin
		push_start = 1'b0;
		push_return = program_counter_reg;
		push_target = prog_data;
		if (state_reg == st_exec && fetch_valid_reg) begin
			if (take_irq) begin
				push_start = 1'b1;
				push_return = program_counter_reg - 16'h0001;
				push_target = irq_vector;
			end else if (op == core_pkg::OP_RELATIVE_SUBROUTINE_CALL) begin
				push_start = 1'b1;
				push_target = program_counter_reg + {{4{prog_data[11]}}, prog_data[11:0]};
			end else if (op == core_pkg::OP_RETURN_GROUP &&
				func == core_pkg::FN_INDIRECT_SUBROUTINE_CALL) begin
				push_start = 1'b1;
				push_target = {gpr[31], gpr[30]};
			end
		end else if (state_reg == st_second && ir_op == core_pkg::OP_CALL_JUMP && ir_reg[0]) begin
			push_start = 1'b1;
		end
	end

	always_comb begin
		req_next = '0;
		stack_down = 1'b0;
		stack_up = 1'b0;
		if (push_start) begin
			req_next = '{stack_top_pointer_reg, push_return[7:0], 1'b1, 1'b0};
			stack_down = 1'b1;
		end else begin
			case (state_reg)
				st_push_high: begin
					req_next = '{stack_top_pointer_reg, return_addr_reg[15:8], 1'b1, 1'b0};
					stack_down = 1'b1;
				end
				st_pop_high: begin
					req_next = '{stack_top_pointer_reg + 16'h0001, 8'h00, 1'b0, 1'b1};
					stack_up = 1'b1;
				end
				st_second: if (ir_op == core_pkg::OP_LOAD_STORE) begin
					req_next = '{prog_data, gpr[ir_rd], ir_reg[0], !ir_reg[0]};
				end
				st_exec: if (run) begin
					case (op)
						core_pkg::OP_STACK_DATA: begin
							if (func[0]) begin
								req_next = '{stack_top_pointer_reg + 16'h0001, 8'h00, 1'b0, 1'b1};
								stack_up = 1'b1;
							end else begin
								req_next = '{stack_top_pointer_reg, gpr[rd], 1'b1, 1'b0};
								stack_down = 1'b1;
							end
						end
						core_pkg::OP_RETURN_GROUP: begin
							req_next = '{stack_top_pointer_reg + 16'h0001, 8'h00, 1'b0, 1'b1};
							stack_up = 1'b1;
						end
						core_pkg::OP_IO_IN: if (!io_internal(io)) begin
							req_next = '{{10'h000, io}, 8'h00, 1'b0, 1'b1};
						end
						core_pkg::OP_IO_OUT: if (!io_internal(io)) begin
							req_next = '{{10'h000, io}, gpr[rd], 1'b1, 1'b0};
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	// Sequencer and fetch; the core clock is used as is, with no divider.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_reg <= st_exec;
			program_counter_reg <= core_pkg::PC_RESET;
			fetch_valid_reg <= 1'b0;
		end else begin
			case (state_reg)
				st_exec: begin
					if (!fetch_valid_reg) begin
						program_counter_reg <= program_counter_reg + 16'h0001;
						fetch_valid_reg <= 1'b1;
					end else if (take_irq) begin
						state_reg <= st_push_high;
					end else begin
						case (op)
							core_pkg::OP_MUL_INT, core_pkg::OP_MUL_FRAC: state_reg <= st_mul;
							core_pkg::OP_CALL_JUMP, core_pkg::OP_LOAD_STORE: begin
								state_reg <= st_second;
								program_counter_reg <= program_counter_reg + 16'h0001;
							end
							core_pkg::OP_RELATIVE_SUBROUTINE_CALL: state_reg <= st_push_high;
							core_pkg::OP_RETURN_GROUP: state_reg <=
								func == core_pkg::FN_INDIRECT_SUBROUTINE_CALL ? st_push_high : st_pop_high;
							core_pkg::OP_STACK_DATA, core_pkg::OP_IO_IN: begin
								if ((op == core_pkg::OP_STACK_DATA) ? func[0] : !io_internal(io)) begin
									state_reg <= st_read_wait;
								end else begin
									program_counter_reg <= program_counter_reg + 16'h0001;
								end
							end
							default: program_counter_reg <= program_counter_reg + 16'h0001;
						endcase
					end
				end
				st_second: begin
					if (ir_op == core_pkg::OP_CALL_JUMP) begin
						if (ir_reg[0]) begin
							state_reg <= st_push_high;
						end else begin
							state_reg <= st_exec;
							program_counter_reg <= prog_data;
							fetch_valid_reg <= 1'b0;
						end
					end else begin
						state_reg <= ir_reg[0] ? st_exec : st_read_wait;
						// A store goes straight back to execute, so it steps past the word
						// that the fetch already holds; a load steps on leaving its wait.
						if (ir_reg[0]) begin
							program_counter_reg <= program_counter_reg + 16'h0001;
						end
					end
				end
				st_push_high: begin
					state_reg <= st_exec;
					program_counter_reg <= target_reg;
					fetch_valid_reg <= 1'b0;
				end
				st_pop_high: state_reg <= st_pop_low;
				st_pop_low: begin
					state_reg <= st_exec;
					program_counter_reg <= {return_addr_reg[15:8], data_rdata};
					fetch_valid_reg <= 1'b0;
				end
				// Leaving a stall: the held word is on the fetch bus now, so the counter
				// moves on here; holding it longer would run that word twice.
				default: begin
					state_reg <= st_exec;
					program_counter_reg <= program_counter_reg + 16'h0001;
				end
			endcase
		end
	end

	// Writes hold the low byte and reads hold the high byte in the temporary byte so both halves land together.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stack_top_pointer_reg <= SRAM_TOP;
			temp_byte_reg <= 8'h00;
			irq_block_reg <= 3'h0;
		end else begin
			if (stack_down) begin
				stack_top_pointer_reg <= stack_top_pointer_reg - core_pkg::STACK_STEP;
			end else if (stack_up) begin
				stack_top_pointer_reg <= stack_top_pointer_reg + core_pkg::STACK_STEP;
			end else if (run && op == core_pkg::OP_IO_OUT &&
				io == core_pkg::IO_STACK_POINTER_HIGH_BYTE) begin
				stack_top_pointer_reg <= {gpr[rd], temp_byte_reg};
			end
			if (run && op == core_pkg::OP_IO_OUT && io == core_pkg::IO_STACK_POINTER_LOW_BYTE) begin
				temp_byte_reg <= gpr[rd];
			end else if (run && op == core_pkg::OP_IO_IN &&
				io == core_pkg::IO_STACK_POINTER_LOW_BYTE) begin
				temp_byte_reg <= stack_top_pointer_reg[15:8];
			end
			if (run && op == core_pkg::OP_IO_OUT) begin
				irq_block_reg <= io == core_pkg::IO_STACK_POINTER_LOW_BYTE ?
					core_pkg::BLOCK_COUNT : 3'h0;
			end else if (run && irq_block_reg != 3'h0) begin
				irq_block_reg <= irq_block_reg - 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (alu_write) begin
			gpr[alu_dest] <= op == core_pkg::OP_LOAD_IMM ? prog_data[7:0] : alu_out[7:0];
		end else if (run && op == core_pkg::OP_IO_IN && io_internal(io)) begin
			gpr[rd] <= io_read;
		end else if (state_reg == st_mul) begin
			gpr[1] <= mul_out[15:8];
			gpr[0] <= mul_out[7:0];
		end else if (state_reg == st_read_wait) begin
			gpr[dest_reg] <= data_rdata;
		end
	end

	// Only the interrupt enable bit is touched on entry and return.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			result_flags_register_reg <= core_pkg::FLAGS_RESET;
		end else if (alu_write && op != core_pkg::OP_LOAD_IMM) begin
			result_flags_register_reg[core_pkg::FLAG_S] <= alu_out[12];
			result_flags_register_reg[core_pkg::FLAG_V] <= alu_out[11];
			result_flags_register_reg[core_pkg::FLAG_N] <= alu_out[10];
			result_flags_register_reg[core_pkg::FLAG_Z] <= alu_out[9];
			if (!alu_kind[1]) begin
				result_flags_register_reg[core_pkg::FLAG_C] <= alu_out[8];
			end
		end else if (state_reg == st_mul) begin
			result_flags_register_reg[core_pkg::FLAG_C] <= mul_out[15];
			result_flags_register_reg[core_pkg::FLAG_Z] <= mul_out == 16'h0000;
		end else if (run && op == core_pkg::OP_IO_OUT && io == core_pkg::IO_RESULT_FLAGS) begin
			result_flags_register_reg <= gpr[rd];
		end else if (take_irq) begin
			result_flags_register_reg[core_pkg::FLAG_I] <= 1'b0;
		end else if (state_reg == st_pop_low && interrupt_return_reg) begin
			result_flags_register_reg[core_pkg::FLAG_I] <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ir_reg <= 16'h0000;
			dest_reg <= 5'h00;
			return_addr_reg <= 16'h0000;
			target_reg <= 16'h0000;
			interrupt_return_reg <= 1'b0;
			irq_ack_reg <= 1'b0;
			data_req_reg <= '0;
		end else begin
			data_req_reg <= req_next;
			irq_ack_reg <= take_irq;
			if (run) begin
				ir_reg <= prog_data;
				dest_reg <= rd;
				interrupt_return_reg <= func == core_pkg::FN_INTERRUPT_RETURN;
			end else if (state_reg == st_second) begin
				dest_reg <= ir_rd;
			end
			if (push_start) begin
				return_addr_reg <= push_return;
				target_reg <= push_target;
			end else if (state_reg == st_pop_high) begin
				return_addr_reg[15:8] <= data_rdata;
			end
		end
	end

	assign prog_addr = program_counter_reg;
	assign data_req = data_req_reg;
	assign irq_ack = irq_ack_reg;
	assign stack_top_pointer = stack_top_pointer_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_reset_entry: assert property ($fell(reset) |-> prog_addr == core_pkg::PC_RESET)
		else $error("Fetch did not start at address zero.");
	a_reset_stack: assert property ($fell(reset) |-> stack_top_pointer == SRAM_TOP)
		else $error("Stack pointer not at SRAM top after reset.");
	a_fetch_advance: assert property (run && op == core_pkg::OP_ALU_REG |=>
		prog_addr == $past(prog_addr) + 16'h0001 && state_reg == st_exec)
		else $error("Fetch did not advance during a one-cycle operation.");
	a_alu_writeback: assert property (run && op == core_pkg::OP_ALU_REG && func == 2'h0 |=>
		gpr[$past(alu_dest)] == 8'($past(alu_out)))
		else $error("Register add result not written back in one cycle.");
	a_zero_flag: assert property (alu_write && op == core_pkg::OP_ALU_REG |=>
		result_flags_register_reg[core_pkg::FLAG_Z] == (gpr[$past(alu_dest)] == 8'h00))
		else $error("Zero flag disagrees with the written result.");
	a_mul_product: assert property (state_reg == st_mul && ir_op == core_pkg::OP_MUL_INT &&
		ir_reg[1:0] == 2'h0 |=> {gpr[1], gpr[0]} == 16'($past(mul_a)) * 16'($past(mul_b)))
		else $error("Unsigned product is wrong.");
	a_mul_latency: assert property (run && op == core_pkg::OP_MUL_INT |=>
		state_reg == st_mul ##1 state_reg == st_exec && prog_addr == $past(prog_addr, 2) + 16'h0001)
		else $error("Multiply did not take two cycles.");
	a_push_step: assert property (run && op == core_pkg::OP_STACK_DATA && !func[0] |=>
		stack_top_pointer == $past(stack_top_pointer) - 16'h0001)
		else $error("Push did not decrement the stack pointer by one.");
	a_call_step: assert property (push_start |-> ##2
		stack_top_pointer == $past(stack_top_pointer, 2) - 16'h0002)
		else $error("Call did not decrement the stack pointer by two.");
	a_return_order: assert property (push_start |=> data_req.we &&
		data_req.wdata == return_addr_reg[7:0] ##1 data_req.we &&
		data_req.wdata == return_addr_reg[15:8] && data_req.addr == $past(data_req.addr) - 16'h0001)
		else $error("Return address bytes pushed in the wrong order.");
	a_spl_block: assert property (run && op == core_pkg::OP_IO_OUT &&
		io == core_pkg::IO_STACK_POINTER_LOW_BYTE |=> irq_block_reg == core_pkg::BLOCK_COUNT && !take_irq)
		else $error("Low pointer write did not hold off interrupts.");
	a_return_resume: assert property (state_reg == st_pop_low |=>
		prog_addr == {return_addr_reg[15:8], $past(data_rdata)} && !fetch_valid_reg)
		else $error("Return did not resume at the popped address.");

	c_multiply: cover property (state_reg == st_mul);
	c_call_return: cover property (state_reg == st_pop_low);
	c_irq_taken: cover property (take_irq);
	c_direct_load: cover property (state_reg == st_second && ir_op == core_pkg::OP_LOAD_STORE);
endmodule

//--- verification/mem_partner.sv
module mem_partner (
	input  wire logic                   sys_clk,
	input  wire logic [15:0]            prog_addr,
	output logic [15:0]                 prog_data,
	input  wire core_pkg::data_req_type data_req,
	output logic [7:0]                  data_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rom [0:255];
	logic [7:0]  ram [0:65535];

	// The program store answers one cycle after the address, like a synchronous ROM.
	always_ff @(posedge sys_clk) begin
		prog_data <= rom[prog_addr[7:0]];
		if (data_req.we)
			ram[data_req.addr] <= data_req.wdata;
	end

	// Outside a read the bus carries a changing pattern, so a stale byte is never reused.
	assign data_rdata = data_req.re ? ram[data_req.addr] : ~prog_addr[7:0];
endmodule

//--- verification/testbench.sv
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, a); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] TOP = 16'h0FFF;
	logic                   sys_clk;
	logic                   reset = 1'b1;
	logic                   irq_req = 1'b0;
	logic [15:0]            irq_vector = 16'h0000;
	logic [15:0]            prog_addr;
	logic [15:0]            prog_data;
	core_pkg::data_req_type data_req;
	logic [7:0]             data_rdata;
	logic                   irq_ack;
	logic [15:0]            stack_top_pointer;
	int                     error_cnt;
	int                     n_checks;
	int                     cyc;
	int                     lt;
	logic [15:0]            pq [$];
	logic [15:0]            wa [$];
	logic [7:0]             wd [$];
	int                     wt [$];

	cpu_core_stack_alu #(.SRAM_TOP(TOP)) uut (
		.sys_clk(sys_clk), .reset(reset), .prog_addr(prog_addr), .prog_data(prog_data),
		.data_req(data_req), .data_rdata(data_rdata), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_ack(irq_ack), .stack_top_pointer(stack_top_pointer));

	mem_partner mem (
		.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data),
		.data_req(data_req), .data_rdata(data_rdata));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Every data write is logged with its cycle so that spacing can be judged too.
	always @(posedge sys_clk) begin
		cyc++;
		if (data_req.we === 1'b1) begin
			wa.push_back(data_req.addr);
			wd.push_back(data_req.wdata);
			wt.push_back(cyc);
		end
		if (cyc == 4000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	function automatic logic [15:0] w3(logic [3:0] op, int d, int r, int f);
		return {op, 5'(d), 5'(r), 2'(f)};
	endfunction

	function automatic logic [15:0] ldi(int d, logic [7:0] k);
		return {4'h5, 4'(d - 16), k};
	endfunction

	function automatic logic [15:0] io(logic [3:0] op, logic [5:0] a, int d);
		return {op, 5'(d), 1'b0, a};
	endfunction

	task automatic load(int base);
		foreach (pq[i]) mem.rom[base + i] = pq[i];
		pq.delete();
	endtask

	task automatic clear();
		for (int i = 0; i < 256; i++) mem.rom[i] = 16'h0000;
	endtask

	task automatic run(int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic restart();
		@(posedge sys_clk) reset <= 1'b1;
		run(6);
		#1 `CHK("prog_addr", 16'h0000, prog_addr)
		`CHK("stack_top_pointer", TOP, stack_top_pointer)
		wa.delete();
		wd.delete();
		wt.delete();
		@(posedge sys_clk) reset <= 1'b0;
	endtask

	task automatic expw(logic [15:0] a, logic [7:0] d, logic [7:0] m);
		logic [15:0] ga;
		logic [7:0]  gd;
		ga = 16'hxxxx;
		gd = 8'hxx;
		lt = 0;
		if (wa.size() > 0) begin
			ga = wa.pop_front();
			gd = wd.pop_front();
			lt = wt.pop_front();
		end
		`CHK("write addr", a, ga)
		`CHK("write data", d & m, gd & m)
	endtask

	task automatic t_flow();
		clear();
		pq = '{ldi(16, 8'h5A), 16'h9000, 16'h0040, io(4'hE, 6'h31, 16)};
		load(0);
		pq = '{io(4'hE, 6'h30, 16), w3(4'hC, 16, 0, 1), 16'h0050, w3(4'hC, 21, 0, 0), 16'h0050,
		       io(4'hE, 6'h31, 21)};
		load(16'h40);
		restart();
		run(2);
		#1 `CHK("prog_addr", 16'h0002, prog_addr)
		run(22);
		expw(16'h0030, 8'h5A, 8'hFF);
		expw(16'h0050, 8'h5A, 8'hFF);
		expw(16'h0031, 8'h5A, 8'hFF);
		`CHK("extra writes", 0, wa.size())
		$display("flow test finished");
	endtask

	task automatic t_alu();
		clear();
		pq = '{ldi(16, 8'hF0), ldi(31, 8'h10), w3(4'h1, 16, 31, 0), io(4'hD, 6'h3F, 18),
		       io(4'hE, 6'h20, 16), io(4'hE, 6'h21, 18), w3(4'h1, 16, 31, 1),
		       io(4'hD, 6'h3F, 18), io(4'hE, 6'h22, 18), {4'h4, 4'hF, 8'h0F},
		       io(4'hD, 6'h3F, 18), io(4'hE, 6'h23, 18)};
		load(0);
		restart();
		run(25);
		expw(16'h0020, 8'h00, 8'hFF);
		expw(16'h0021, 8'h03, 8'h1F);
		expw(16'h0022, 8'h15, 8'h1F);
		expw(16'h0023, 8'h03, 8'h17);
		$display("alu test finished");
	endtask

	task automatic t_mul();
		logic [3:0]  op [5] = '{4'h6, 4'h6, 4'h6, 4'h7, 4'h7};
		int          f [5] = '{0, 1, 2, 0, 1};
		logic [15:0] p [5] = '{16'h02FA, 16'hFFFA, 16'hFFFA, 16'h05F4, 16'hFFF4};
		int          t1;
		clear();
		pq = '{ldi(16, 8'hFE), ldi(17, 8'h03)};
		foreach (op[i]) pq = {pq, w3(op[i], 16, 17, f[i]), io(4'hE, 6'h24, 0), io(4'hE, 6'h25, 1)};
		load(0);
		restart();
		run(30);
		foreach (op[i]) begin
			expw(16'h0024, p[i][7:0], 8'hFF);
			if (i > 0) `CHK("mul spacing", 3, lt - t1)
			expw(16'h0025, p[i][15:8], 8'hFF);
			t1 = lt;
		end
		$display("multiply test finished");
	endtask

	task automatic t_stack();
		clear();
		pq = '{ldi(16, 8'hAA), w3(4'h8, 16, 0, 0), 16'h9001, 16'h0010, w3(4'h8, 17, 0, 1),
		       io(4'hE, 6'h27, 17), 16'hA019, io(4'hE, 6'h29, 17)};
		load(0);
		pq = '{io(4'hD, 6'h3D, 20), io(4'hE, 6'h26, 20), 16'hB000};
		load(16'h10);
		pq = '{io(4'hD, 6'h3D, 20), io(4'hE, 6'h28, 20), 16'hB000};
		load(16'h20);
		restart();
		run(45);
		expw(16'h0FFF, 8'hAA, 8'hFF);
		expw(16'h0FFE, 8'h04, 8'hFF);
		expw(16'h0FFD, 8'h00, 8'hFF);
		expw(16'h0026, 8'hFC, 8'hFF);
		expw(16'h0027, 8'hAA, 8'hFF);
		expw(16'h0FFF, 8'h07, 8'hFF);
		expw(16'h0FFE, 8'h00, 8'hFF);
		expw(16'h0028, 8'hFD, 8'hFF);
		expw(16'h0029, 8'hAA, 8'hFF);
		`CHK("stack_top_pointer", TOP, stack_top_pointer)
		$display("stack test finished");
	endtask

	task automatic t_spio();
		clear();
		// Low byte goes first and the new stack stays well above the start of SRAM.
		pq = '{ldi(16, 8'h80), io(4'hE, 6'h3D, 16), ldi(16, 8'h0A), io(4'hE, 6'h3E, 16),
		       io(4'hD, 6'h3D, 18), io(4'hD, 6'h3E, 19), io(4'hE, 6'h2A, 18),
		       io(4'hE, 6'h2B, 19), w3(4'h8, 18, 0, 0)};
		load(0);
		restart();
		run(20);
		expw(16'h002A, 8'h80, 8'hFF);
		expw(16'h002B, 8'h0A, 8'hFF);
		expw(16'h0A80, 8'h80, 8'hFF);
		`CHK("stack_top_pointer", 16'h0A7F, stack_top_pointer)
		$display("pointer io test finished");
	endtask

	task automatic t_irq();
		clear();
		pq = '{ldi(16, 8'h81), io(4'hE, 6'h3F, 16)};
		load(0);
		pq = '{io(4'hD, 6'h3F, 20), io(4'hE, 6'h2C, 20)};
		load(16'h30);
		@(posedge sys_clk) irq_vector <= 16'h0030;
		restart();
		run(8);
		irq_req <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			#1;
			if (irq_ack === 1'b1) break;
		end
		`CHK("irq_ack", 1'b1, irq_ack)
		@(posedge sys_clk) irq_req <= 1'b0;
		run(15);
		expw(16'h0FFF, 8'h00, 8'h00);
		expw(16'h0FFE, 8'h00, 8'h00);
		expw(16'h002C, 8'h01, 8'h9F);
		`CHK("stack_top_pointer", 16'h0FFD, stack_top_pointer)
		$display("interrupt test finished");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		t_flow();
		t_alu();
		t_mul();
		t_stack();
		t_spio();
		t_irq();
		report_and_stop();
	end
endmodule
